// file: test_tmi_timer_match_irq.sv
// Self-checking bench of the timer match interrupt flags
`timescale 1ns/1ps
module test_tmi_timer_match_irq;
  import tmi_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [7:0] paddr = 8'h00, a;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, d;
  logic [6:0] fire = 7'h00, match;
  logic pready, pslverr, irq;
  int miscompares = 0, tests_run = 0, i;
  always #20 clk = ~clk;
  tmi_timer_model i_tm (.clk(clk), .fire(fire), .match(match));
  tmi_timer_match_irq i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mod0_p_match(match[0]),
    .mod0_a_match(match[1]), .mod2_p_match(match[2]), .mod2_a_match(match[3]),
    .mod1_p_match(match[4]), .mod1_a_match(match[5]), .mod1_b_match(match[6]), .irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // Setup then access; f puts matches into the access cycle
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     input logic [6:0] f = 7'h00);
    int n;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata, fire} <= {1'b1, w, ad, wd, f};
    @(posedge clk);
    penable <= 1'b1;
    fire <= 7'h00;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // Flag position of source i in its match word
  function automatic logic [31:0] flag_of(int k);
    return 32'(1 << (FLAG_LSB + k % 4));
  endfunction : flag_of
  task automatic irq_is(input logic v);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'(v));
  endtask : irq_is
  initial begin
    d = $urandom(32'hA250_C644);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Every word comes out of reset clear
    for (i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    // Each source lands on its own flag and status bit, enables off
    for (i = 0; i < 7; i++) begin
      a = (i < 4) ? OFS_MATCH0 : OFS_MATCH1;
      apb(1'b0, OFS_CTRL, 32'h0, 7'(1 << i));
      apb(1'b0, a, 32'h0);
      chk(rd, flag_of(i));
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd, 32'(1 << i));
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, a, 32'h0);
    end
    // Random words, holes stay zero; unmapped places refuse
    repeat (8) begin
      d = $urandom;
      apb(1'b1, OFS_MATCH1, d);
      apb(1'b0, OFS_MATCH1, 32'h0);
      chk(rd, d & 32'h0000_0077);
      apb(1'b1, OFS_MATCH0, d);
      apb(1'b0, OFS_MATCH0, 32'h0);
      chk(rd, d & 32'h0000_00FF);
      apb(1'b1, 8'h14 + 8'($urandom_range(0, 200)), d);
      chk(32'(er), 32'h1);
    end
    apb(1'b1, OFS_MATCH0, 32'h0);
    // Enable passes, global enable gates, mask path too
    apb(1'b1, OFS_MATCH1, 32'h0000_0001);
    apb(1'b0, OFS_STAT, 32'h0, 7'h10);
    irq_is(1'b0);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    irq_is(1'b1);
    apb(1'b1, OFS_MATCH1, 32'h0000_0010);
    irq_is(1'b0);
    apb(1'b1, OFS_MASK, 32'h0000_0010);
    irq_is(1'b1);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd, 32'h0000_0010);
    irq_is(1'b0);
    // Match in the cycle of a clearing write keeps its flag
    apb(1'b1, OFS_MATCH1, 32'h0, 7'h40);
    apb(1'b0, OFS_MATCH1, 32'h0);
    chk(rd, 32'h0000_0040);
    // Match landing on the edge that launches a read's setup
    apb(1'b1, OFS_MATCH1, 32'h0);
    @(posedge clk);
    fire <= 7'h40;
    @(posedge clk);
    fire <= 7'h00;
    apb(1'b0, OFS_MATCH1, 32'h0);
    chk(rd, 32'h0000_0040);
    print_verdict();
  end
endmodule : test_tmi_timer_match_irq

// file: tmi_bank_if.sv
// Interface: carrier between the bus logic and one flag-and-enable bank
`timescale 1ns/1ps
interface tmi_bank_if #(
  parameter int N = 2
);
  import tmi_pkg::*;
  logic [N-1:0] match;
  logic [N-1:0] flag;
  logic [N-1:0] en;
  logic         wr;
  tmi_byte_t    wdata;

  modport bank (input match, input wr, input wdata, output flag, output en);
  modport ctrl (output match, output wr, output wdata, input flag, input en);
endinterface : tmi_bank_if

// file: tmi_flag_bank.sv
// One match register: request flags and their enable bits
`timescale 1ns/1ps
module tmi_flag_bank
  import tmi_pkg::*;
#(
  parameter int N = 2
) (
  input wire logic clk,
  input wire logic rst,
  tmi_bank_if.bank bus
);

  // Elaboration check: flags must fit the upper nibble
  if (N < 1 || N > REG_W - FLAG_LSB) begin : g_bad_n
    $error("tmi_flag_bank: bad source count");
  end

  logic [N-1:0] flag_reg;
  logic [N-1:0] en_reg;
  wire  [N-1:0] flag_next;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_src
      // Match sets regardless of enable; set beats a clearing write
      assign flag_next[i] = bus.match[i] ? 1'b1 :
                            bus.wr ? bus.wdata[FLAG_LSB+i] : flag_reg[i];
    end
  endgenerate

  // Whole vectors in one process, so each interface signal has one driver
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_reg <= '0;
      en_reg   <= '0;
    end else begin
      flag_reg <= flag_next;
      if (bus.wr) begin
        en_reg <= bus.wdata[EN_LSB +: N];
      end
    end
  end

  assign bus.flag = flag_reg;
  assign bus.en   = en_reg;

endmodule : tmi_flag_bank

// file: tmi_pkg.sv
// Package: register map, field layout and reset values of the timer match flags
package tmi_pkg;

  localparam int REG_W = 8;
  typedef logic [REG_W-1:0] tmi_byte_t;

  // Byte offsets of the register words on the APB
  localparam logic [7:0] OFS_MATCH0 = 8'h00;
  localparam logic [7:0] OFS_MATCH1 = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam logic [7:0] OFS_STAT   = 8'h0C;
  localparam logic [7:0] OFS_MASK   = 8'h10;

  // Flags sit in the upper nibble, enables in the lower one
  localparam int FLAG_LSB = 4;
  localparam int EN_LSB   = 0;

  // Sources per register
  localparam int MATCH0_SRC_SMALL = 2;   // Module 0 P and A
  localparam int MATCH0_SRC_LARGE = 4;   // Plus module 2 P and A
  localparam int MATCH1_SRC       = 3;   // Module 1 P, A and B

  // Event status and mask layout
  localparam int STAT_W       = 7;
  localparam int STAT_M0_LSB  = 0;
  localparam int STAT_M1_LSB  = 4;

  // Global enable bit in the control word
  localparam int CTRL_GIE_BIT = 0;

  localparam tmi_byte_t   RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage : tmi_pkg

// file: tmi_timer_match_irq.sv
// Timer match interrupt flags: APB register file, flag banks and interrupt output
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module tmi_timer_match_irq
  import tmi_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mod0_p_match,
  input  wire logic        mod0_a_match,
  input  wire logic        mod2_p_match,
  input  wire logic        mod2_a_match,
  input  wire logic        mod1_p_match,
  input  wire logic        mod1_a_match,
  input  wire logic        mod1_b_match,
  output logic             irq
);

  localparam int N0 = LARGE_VARIANT ? MATCH0_SRC_LARGE : MATCH0_SRC_SMALL;

  // Elaboration check: every source needs a status bit
  if (N0 + MATCH1_SRC > STAT_W) begin : g_bad_w
    $error("tmi_timer_match_irq: status too narrow");
  end

  tmi_bank_if #(.N(N0))         b0 ();
  tmi_bank_if #(.N(MATCH1_SRC)) b1 ();

  tmi_flag_bank #(.N(N0)) u_bank0 (
    .clk (clk),
    .rst (rst),
    .bus (b0)
  );

  tmi_flag_bank #(.N(MATCH1_SRC)) u_bank1 (
    .clk (clk),
    .rst (rst),
    .bus (b1)
  );

  // Registers
  logic [31:0]       prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic              irq_reg;
  logic              gie_reg;
  logic [STAT_W-1:0] stat_reg;
  logic [STAT_W-1:0] stat_next;
  logic [STAT_W-1:0] mask_reg;

  // Bus phase decode: zero wait state, pready raised in the access cycle
  wire        setup    = psel & ~penable;
  wire        done     = psel & penable & pready_reg;
  wire        wr_done  = done & pwrite & pstrb[0];  // Only lane 0 holds data
  wire        rd_done  = done & ~pwrite;
  wire        sel_m0   = (paddr == OFS_MATCH0);
  wire        sel_m1   = (paddr == OFS_MATCH1);
  wire        sel_ctrl = (paddr == OFS_CTRL);
  wire        sel_stat = (paddr == OFS_STAT);
  wire        sel_mask = (paddr == OFS_MASK);
  wire        mapped   = sel_m0 | sel_m1 | sel_ctrl | sel_stat | sel_mask;
  wire        stat_clr = rd_done & sel_stat;

  // Match pulses into the banks; module 2 absent on the small part
  generate
    if (LARGE_VARIANT) begin : g_large
      assign b0.match = {mod2_a_match, mod2_p_match, mod0_a_match, mod0_p_match};
    end else begin : g_small
      assign b0.match = {mod0_a_match, mod0_p_match};
    end
  endgenerate
  assign b1.match = {mod1_b_match, mod1_a_match, mod1_p_match};

  assign b0.wr    = wr_done & sel_m0;
  assign b0.wdata = pwdata[REG_W-1:0];
  assign b1.wr    = wr_done & sel_m1;
  assign b1.wdata = pwdata[REG_W-1:0];

  // Read views; absent bank bits zero-extend, so they read zero
  wire tmi_byte_t rd_m0 = tmi_byte_t'(b0.flag) << FLAG_LSB | tmi_byte_t'(b0.en);
  wire tmi_byte_t rd_m1 = tmi_byte_t'(b1.flag) << FLAG_LSB | tmi_byte_t'(b1.en);

  wire [31:0] rd_word =
      sel_m0   ? 32'(rd_m0) :
      sel_m1   ? 32'(rd_m1) :
      sel_ctrl ? 32'(gie_reg) << CTRL_GIE_BIT :
      sel_stat ? 32'(stat_reg) :
      sel_mask ? 32'(mask_reg) : RST_WORD;

  // Event capture; a new event wins over the clear by read
  wire [STAT_W-1:0] events = STAT_W'(b0.match) << STAT_M0_LSB |
                             STAT_W'(b1.match) << STAT_M1_LSB;
  assign stat_next = events | (stat_clr ? '0 : stat_reg);

  // Gated requests: a flag needs its enable, a status bit its mask; global enable needed by both
  wire req_any  = |(b0.flag & b0.en) | |(b1.flag & b1.en);
  wire irq_next = gie_reg & (req_any | |(stat_reg & mask_reg));

  // Bus answer: data latched in setup, ready held one access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_reg  <= RST_WORD;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~mapped;
      prdata_reg  <= setup & ~pwrite ? rd_word : RST_WORD;
    end
  end

  // Control, mask, status and interrupt line
  always_ff @(posedge clk) begin
    if (rst) begin
      gie_reg  <= 1'b0;
      mask_reg <= '0;
      stat_reg <= '0;
      irq_reg  <= 1'b0;
    end else begin
      if (wr_done & sel_ctrl) begin
        gie_reg <= pwdata[CTRL_GIE_BIT];
      end
      if (wr_done & sel_mask) begin
        mask_reg <= pwdata[STAT_W-1:0];
      end
      stat_reg <= stat_next;
      irq_reg  <= irq_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;

endmodule : tmi_timer_match_irq

// file: tmi_timer_match_irq_properties.sv
// Checker of bus timing, read-back layout and match capture
`timescale 1ns/1ps
module tmi_timer_match_irq_properties
  import tmi_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mod1_b_match
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // No wait states, answer stands one cycle
  rdy_one_a: assert property (psel && !penable |=> pready) else $error("late");
  rdy_stand_a: assert property (pready |=> !pready) else $error("long");
  err_pair_a: assert property (pslverr |-> pready && prdata == '0) else $error("err");
  idle_zero_a: assert property (!pready |-> prdata == '0) else $error("idle");
  unmap_err_a: assert property (pready && paddr > OFS_MASK |-> pslverr) else $error("map");
  high_zero_a: assert property (pready |-> prdata[31:8] == '0) else $error("high");
  // Read of the second match word
  m1_gap_a: assert property (pready && !pwrite && paddr == OFS_MATCH1
    |-> !prdata[7] && !prdata[3]) else $error("gap");
  // Match on the edge that launches the read's setup must show, whatever the enable
  m1b_seen_a: assert property (pready && !pwrite && paddr == OFS_MATCH1
    && $past(mod1_b_match, 2) |-> prdata[6]) else $error("lost");
endmodule : tmi_timer_match_irq_properties
bind tmi_timer_match_irq tmi_timer_match_irq_properties i_chk (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mod1_b_match(mod1_b_match));

// file: tmi_timer_model.sv
// Timer comparator model: match pulses on request
`timescale 1ns/1ps
module tmi_timer_model (
  input  wire logic       clk,
  input  wire logic [6:0] fire,
  output logic      [6:0] match
);
  // Hit one cycle after each request, lasting as long as the request
  always @(posedge clk) match <= fire;
endmodule : tmi_timer_model
